// [rtl/ddr3r_cmd_addr.sv]
/*
  Command, address and clock-enable front end of a two-rank memory package.
  Pins are sampled by ref_clk; the memory clock pair is found by edge detect,
  so the memory clock must be far slower than ref_clk.
*/
`timescale 1ns/1ps
`include "ddr3r_consts.svh"

// How it works
// - Command and address captured where true clock rises, complement falls.
// - Activate takes sixteen address bits as the row of the bank.
// - Read or write takes ten column bits; bit ten asks auto precharge.
// - Precharge closes one bank, or all banks when bit ten high.
// - Load mode writes the address value into a mode register.
// - Bank inputs pick mode register zero to three for load mode.
// - Bank inputs pick one of eight banks for bank commands.
// - With on-the-fly chop, bit twelve high gives eight beats, low four.
// - Clock enable low enters self refresh with a refresh command, else power-down by bank state.
// - Entry and power-down exit synchronous; self-refresh exit needs no clock.
// - Power-down ignores all inputs but clock, enable, reset, termination.
// - Self refresh ignores all inputs but clock enable and reset.
// - Two ranks, each with own select, enable, termination; shared lines.
// - A rank with select high ignores every command.
// - Command is the strobe, enable and select levels at one edge.
module ddr3r_cmd_addr #(
  parameter int RANKS = 2
) (
  input  wire logic                         ref_clk,
  input  wire logic                         arst_n,
  input  wire logic                         ckP,
  input  wire logic                         ckN,
  input  wire logic [RANKS-1:0]             csN,
  input  wire logic [RANKS-1:0]             ckeIn,
  input  wire logic [RANKS-1:0]             odtIn,
  input  wire logic                         rasN,
  input  wire logic                         casN,
  input  wire logic                         weN,
  input  wire logic [`DDR3R_BANK_W-1:0]     bankIn,
  input  wire logic [`DDR3R_ROW_W-1:0]      addrIn,
  input  wire logic                         resetPinN,
  output logic      [RANKS-1:0]             rankStrobe,
  output ddr3r_pkg::ddr3r_cmd_e             cmdKind,
  output logic      [`DDR3R_BANK_W-1:0]     cmdBank,
  output logic      [`DDR3R_ROW_W-1:0]      cmdAddr,
  output logic      [`DDR3R_COL_W-1:0]      cmdCol,
  output logic                              cmdAutoPre,
  output logic                              cmdBurstChop,
  output logic      [RANKS*`DDR3R_BANKS-1:0] bankOpen,
  output logic      [RANKS*2-1:0]           pwrState,
  output logic      [RANKS-1:0]             odtActive,
  output logic      [RANKS*64-1:0]          modeRegs
);

  localparam int SW = 2 + 3 * RANKS + 3 + `DDR3R_BANK_W + `DDR3R_ROW_W + 1;
  // Select idle high, strobes idle high, reset pin idle high
  localparam logic [SW-1:0] SYNC_INIT = {2'h0, {RANKS{1'b1}}, {(2 * RANKS){1'b0}}, 3'h7,
                                         {(`DDR3R_BANK_W + `DDR3R_ROW_W){1'b0}}, 1'h1};

  logic [SW-1:0]              syncOut;
  logic                       ckPS;
  logic                       ckNS;
  logic [RANKS-1:0]           csS;
  logic [RANKS-1:0]           ckeS;
  logic [RANKS-1:0]           odtS;
  logic                       rasS;
  logic                       casS;
  logic                       weS;
  logic [`DDR3R_BANK_W-1:0]   baS;
  logic [`DDR3R_ROW_W-1:0]    adS;
  logic                       rstPinS;
  logic                       ckPrev_q;
  logic [RANKS-1:0]           accept;
  logic [RANKS-1:0]           chopW;

  ddr3r_sync #(
    .W    (SW),
    .INIT (SYNC_INIT)
  ) u_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .pinIn   ({ckP, ckN, csN, ckeIn, odtIn, rasN, casN, weN, bankIn, addrIn, resetPinN}),
    .syncOut (syncOut)
  );

  assign {ckPS, ckNS, csS, ckeS, odtS, rasS, casS, weS, baS, adS, rstPinS} = syncOut;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ckPrev_q <= 1'b0;
    end else begin
      ckPrev_q <= ckPS;
    end
  end

  wire ckEdge = ckPS & ~ckPrev_q & ~ckNS;
  wire [2:0] cmdCodeW = {rasS, casS, weS};
  wire isMode  = cmdCodeW == ddr3r_pkg::DDR3R_CMD_MODE;
  wire isRef   = cmdCodeW == ddr3r_pkg::DDR3R_CMD_REF;
  wire isPre   = cmdCodeW == ddr3r_pkg::DDR3R_CMD_PRE;
  wire isAct   = cmdCodeW == ddr3r_pkg::DDR3R_CMD_ACT;
  wire isRdWr  = (cmdCodeW == ddr3r_pkg::DDR3R_CMD_READ) | (cmdCodeW == ddr3r_pkg::DDR3R_CMD_WRITE);
  wire [`DDR3R_BANKS-1:0] bankHot = `DDR3R_BANKS'(1) << baS;
  wire anyAccept = |accept;
  // One select low per edge is assumed, so an OR picks the right rank
  wire chopPick  = |(accept & chopW);

  // row, column and auto precharge, bank
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdKind      <= ddr3r_pkg::DDR3R_CMD_NOP;
      cmdBank      <= '0;
      cmdAddr      <= '0;
      cmdCol       <= '0;
      cmdAutoPre   <= 1'b0;
      cmdBurstChop <= 1'b0;
    end else if (anyAccept) begin
      cmdKind      <= ddr3r_pkg::ddr3r_cmd_e'(cmdCodeW);
      cmdBank      <= baS;
      cmdAddr      <= adS;
      cmdCol       <= adS[`DDR3R_COL_W-1:0];
      cmdAutoPre   <= adS[`DDR3R_A_AUTOPRE];
      cmdBurstChop <= chopPick;
    end
  end

  // one independent state set per rank
  genvar r;
  generate
    for (r = 0; r < RANKS; r++) begin : g_rank
      ddr3r_pkg::ddr3r_pwr_e   pwr_q;
      ddr3r_pkg::ddr3r_pwr_e   pwr_d;
      logic [`DDR3R_BANKS-1:0] open_q;
      logic [`DDR3R_BANKS-1:0] open_d;
      logic                    strobe_q;
      logic                    odt_q;
      logic [`DDR3R_MR_W-1:0]  mr_q [`DDR3R_NUM_MR];

      wire isActive = pwr_q == ddr3r_pkg::DDR3R_PWR_ACTIVE;
      // select high masks; receivers off when asleep
      assign accept[r] = ckEdge & ~csS[r] & ckeS[r] & isActive & rstPinS;
      wire srefReq = ~csS[r] & isRef;
      wire [1:0] blMode = mr_q[0][`DDR3R_MR_BL_LSB +: 2];
      // chop from bit twelve only when enabled on the fly
      assign chopW[r] = (blMode == `DDR3R_MR_BL_OTF) ? ~adS[`DDR3R_A_CHOP] : (blMode == `DDR3R_MR_BL_BC4);

      // precharge one or all; auto precharge closes bank
      assign open_d = !rstPinS                                     ? '0 :
                      (accept[r] & isAct)                          ? (open_q | bankHot) :
                      (accept[r] & isPre & adS[`DDR3R_A_AUTOPRE])  ? '0 :
                      (accept[r] & isPre)                          ? (open_q & ~bankHot) :
                      (accept[r] & isRdWr & adS[`DDR3R_A_AUTOPRE]) ? (open_q & ~bankHot) :
                                                                     open_q;

      // entry by refresh command and bank state; self-refresh exit unclocked
      always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
          ddr3r_pkg::DDR3R_PWR_ACTIVE: begin
            if (ckEdge && !ckeS[r]) begin
              pwr_d = srefReq ? ddr3r_pkg::DDR3R_PWR_SREF :
                      (|open_q) ? ddr3r_pkg::DDR3R_PWR_APD : ddr3r_pkg::DDR3R_PWR_PPD;
            end
          end
          ddr3r_pkg::DDR3R_PWR_PPD,
          ddr3r_pkg::DDR3R_PWR_APD: begin
            if (ckEdge && ckeS[r]) begin
              pwr_d = ddr3r_pkg::DDR3R_PWR_ACTIVE;
            end
          end
          ddr3r_pkg::DDR3R_PWR_SREF: begin
            if (ckeS[r]) begin
              pwr_d = ddr3r_pkg::DDR3R_PWR_ACTIVE;
            end
          end
          default: pwr_d = ddr3r_pkg::DDR3R_PWR_ACTIVE;
        endcase
        if (!rstPinS) begin
          pwr_d = ddr3r_pkg::DDR3R_PWR_ACTIVE;
        end
      end

      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          pwr_q    <= ddr3r_pkg::DDR3R_PWR_ACTIVE;
          open_q   <= '0;
          strobe_q <= 1'b0;
          odt_q    <= 1'b0;
        end else begin
          pwr_q    <= pwr_d;
          open_q   <= open_d;
          strobe_q <= accept[r];
          // termination control dropped in self refresh
          odt_q    <= (pwr_d == ddr3r_pkg::DDR3R_PWR_SREF) ? 1'b0 : (ckEdge ? odtS[r] : odt_q);
        end
      end

      // opcode stored, register chosen by bank bits
      always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
          for (int i = 0; i < `DDR3R_NUM_MR; i++) begin
            mr_q[i] <= '0;
          end
        end else if (accept[r] && isMode && !baS[2]) begin
          mr_q[baS[1:0]] <= adS;
        end
      end

      assign rankStrobe[r]                                  = strobe_q;
      assign bankOpen[r*`DDR3R_BANKS +: `DDR3R_BANKS]        = open_q;
      assign pwrState[r*2 +: 2]                             = pwr_q;
      assign odtActive[r]                                   = odt_q;
      for (genvar m = 0; m < `DDR3R_NUM_MR; m++) begin : g_mr
        assign modeRegs[r*64 + m*16 +: 16] = mr_q[m];
      end

      cs_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        strobe_q |-> $past(ckEdge) && !$past(csS[r]))
        else $error("Strobe without select low at a clock edge");
      act_open_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        accept[r] && isAct |=> open_q[$past(baS)] && strobe_q)
        else $error("Activate did not open its bank");
      pre_all_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        accept[r] && isPre && adS[`DDR3R_A_AUTOPRE] |=> open_q == '0)
        else $error("Precharge all left a bank open");
      pre_one_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        accept[r] && isPre && !adS[`DDR3R_A_AUTOPRE] |=>
          (open_q | $past(bankHot)) == ($past(open_q) | $past(bankHot)) && !open_q[$past(baS)])
        else $error("Single precharge touched the wrong banks");
      mrs_load_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        accept[r] && isMode && !baS[2] |=> mr_q[$past(baS[1:0])] == $past(adS))
        else $error("Mode register not loaded with opcode");
      pd_entry_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        isActive && ckEdge && !ckeS[r] && !srefReq && rstPinS |=>
          pwr_q == ($past(|open_q) ? ddr3r_pkg::DDR3R_PWR_APD : ddr3r_pkg::DDR3R_PWR_PPD))
        else $error("Wrong power-down kind entered");
      sref_exit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pwr_q == ddr3r_pkg::DDR3R_PWR_SREF && ckeS[r] |=> pwr_q == ddr3r_pkg::DDR3R_PWR_ACTIVE)
        else $error("Self refresh not left on clock enable high");
      sleep_mask_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !isActive |=> !strobe_q)
        else $error("Command taken while asleep");
      sref_odt_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        pwr_q == ddr3r_pkg::DDR3R_PWR_SREF |-> !odt_q)
        else $error("Termination active in self refresh");
      chop_otf_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        accept[r] && isRdWr && blMode == `DDR3R_MR_BL_OTF |=> cmdBurstChop == !$past(adS[`DDR3R_A_CHOP]))
        else $error("On-the-fly chop not taken from bit twelve");
    end
  endgenerate

endmodule

// [common/ddr3r_consts.svh]
/*
  Constants for the dual-rank command and address front end: pin field
  positions, mode register layout and the timing figures of the memory.
  Assumes inclusion by bare name from design files only.
*/
`ifndef DDR3R_CONSTS_SVH
`define DDR3R_CONSTS_SVH

// Address pin roles
`define DDR3R_ROW_W        16
`define DDR3R_COL_W        10
`define DDR3R_A_AUTOPRE    10
`define DDR3R_A_CHOP       12
`define DDR3R_BANK_W       3
`define DDR3R_BANKS        8
`define DDR3R_NUM_MR       4
`define DDR3R_MR_W         16

// Burst length field, mode register 0 bits [1:0]
`define DDR3R_MR_BL_LSB    0
`define DDR3R_MR_BL_FIXED8 2'h0
`define DDR3R_MR_BL_OTF    2'h1
`define DDR3R_MR_BL_BC4    2'h2

// Refresh demand on the controller
`define DDR3R_REF_COUNT    8192
`define DDR3R_REF_WIN_MS   64
`define DDR3R_REF_HOT_MS   32

// Speed grades, times in picoseconds, latencies in clocks
`define DDR3R_TCK_FAST_PS  1071
`define DDR3R_CL_FAST      13
`define DDR3R_TRCD_FAST_PS 13910
`define DDR3R_TRP_FAST_PS  13910
`define DDR3R_TCK_SLOW_PS  1250
`define DDR3R_CL_SLOW      11
`define DDR3R_TRCD_SLOW_PS 13750
`define DDR3R_TRP_SLOW_PS  13750

`endif

// [common/ddr3r_pkg.sv]
/*
  Types for the dual-rank command and address front end.
  Assumes the encodings match the row strobe, column strobe and write
  enable levels as sampled, active low.
*/
package ddr3r_pkg;

  typedef enum logic [2:0] {
    DDR3R_CMD_MODE   = 3'b000,
    DDR3R_CMD_REF    = 3'b001,
    DDR3R_CMD_PRE    = 3'b010,
    DDR3R_CMD_ACT    = 3'b011,
    DDR3R_CMD_WRITE  = 3'b100,
    DDR3R_CMD_READ   = 3'b101,
    DDR3R_CMD_ZQ     = 3'b110,
    DDR3R_CMD_NOP    = 3'b111
  } ddr3r_cmd_e;

  typedef enum logic [1:0] {
    DDR3R_PWR_ACTIVE = 2'b00,
    DDR3R_PWR_PPD    = 2'b01,
    DDR3R_PWR_APD    = 2'b10,
    DDR3R_PWR_SREF   = 2'b11
  } ddr3r_pwr_e;

endpackage

// [rtl/ddr3r_sync.sv]
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes each bit is a slow level relative to ref_clk; no bundle coherence.
*/
`timescale 1ns/1ps
module ddr3r_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] syncOut
);

  logic [W-1:0] meta_q;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q  <= INIT;
      syncOut <= INIT;
    end else begin
      meta_q  <= pinIn;
      syncOut <= meta_q;
    end
  end

endmodule

// [test/ddr3r_ctrl_model.sv]
/*
  Behavioural memory controller driving the command, address and clock
  enable pins of both ranks. Assumes the caller steps ref_clk and that
  the memory clock only runs while a command frame is being sent.
*/
`timescale 1ns/1ps
module ddr3r_ctrl_model (
  input  wire logic        ref_clk,
  output logic             ckP,
  output logic             ckN,
  output logic [1:0]       csN,
  output logic [1:0]       ckeIn,
  output logic [1:0]       odtIn,
  output logic             rasN,
  output logic             casN,
  output logic             weN,
  output logic [2:0]       bankIn,
  output logic [15:0]      addrIn,
  output logic             resetPinN
);
  int refCount[2] = '{0, 0};

  initial begin
    {ckP, ckN, rasN, casN, weN, resetPinN} = 6'h1F;
    csN = 2'h3;
    // Enable high before the first edge, else power-down at once
    ckeIn = 2'h3;
    odtIn = 2'h0;
    bankIn = 3'h0;
    addrIn = 16'h0000;
  end

  // One memory clock period of 400 ns per command, pins steady around the rise
  // real grades cycle near 1 ns; frames scaled to the sampled pins
  task automatic issue(input logic [1:0] cs, input ddr3r_pkg::ddr3r_cmd_e cmd,
                       input logic [2:0] ba, input logic [15:0] a);
    @(posedge ref_clk);
    csN <= cs;
    {rasN, casN, weN} <= cmd;
    bankIn <= ba;
    addrIn <= a;
    for (int r = 0; r < 2; r++) begin
      if (!cs[r] && cmd == ddr3r_pkg::DDR3R_CMD_REF) refCount[r]++;
    end
    // Three cycles of setup cover the two-stage pin synchroniser
    repeat (3) @(posedge ref_clk);
    ckP <= 1'b1;
    ckN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ckP <= 1'b0;
    ckN <= 1'b1;
    // Deselect; stale bank and address inverted so nothing lingers usable
    csN <= 2'h3;
    {rasN, casN, weN} <= 3'h7;
    bankIn <= ~ba;
    addrIn <= ~a;
  endtask
endmodule

// [test/tb.sv]
/*
  Self-checking bench for the dual-rank command and address front end.
  Assumes the controller model sends one command per memory clock frame.
*/
`timescale 1ns/1ps
module tb;
  logic                      ref_clk = 1'b0;
  logic                      arst_n = 1'b0;
  logic                      ckP, ckN, rasN, casN, weN, resetPinN;
  logic [1:0]                csN, ckeIn, odtIn, rankStrobe, odtActive;
  logic [2:0]                bankIn, cmdBank;
  logic [15:0]               addrIn, cmdAddr, bankOpen;
  ddr3r_pkg::ddr3r_cmd_e     cmdKind;
  logic [9:0]                cmdCol;
  logic                      cmdAutoPre, cmdBurstChop;
  logic [3:0]                pwrState;
  logic [127:0]              modeRegs;
  int                        badCount = 0;
  int                        totalChecks = 0;
  int                        strobeCnt[2] = '{0, 0};

  always #25 ref_clk = ~ref_clk;

  ddr3r_ctrl_model m (.ref_clk(ref_clk), .ckP(ckP), .ckN(ckN), .csN(csN), .ckeIn(ckeIn),
    .odtIn(odtIn), .rasN(rasN), .casN(casN), .weN(weN), .bankIn(bankIn), .addrIn(addrIn),
    .resetPinN(resetPinN));

  ddr3r_cmd_addr DUT (.ref_clk(ref_clk), .arst_n(arst_n), .ckP(ckP), .ckN(ckN), .csN(csN),
    .ckeIn(ckeIn), .odtIn(odtIn), .rasN(rasN), .casN(casN), .weN(weN), .bankIn(bankIn),
    .addrIn(addrIn), .resetPinN(resetPinN), .rankStrobe(rankStrobe), .cmdKind(cmdKind),
    .cmdBank(cmdBank), .cmdAddr(cmdAddr), .cmdCol(cmdCol), .cmdAutoPre(cmdAutoPre),
    .cmdBurstChop(cmdBurstChop), .bankOpen(bankOpen), .pwrState(pwrState),
    .odtActive(odtActive), .modeRegs(modeRegs));

  // Counted at the falling edge so a check right after a frame sees it
  always @(negedge ref_clk) begin
    for (int r = 0; r < 2; r++) begin
      if (rankStrobe[r] === 1'b1) strobeCnt[r]++;
    end
  end

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic set_cke(input logic [1:0] v);
    @(posedge ref_clk);
    m.ckeIn <= v;
  endtask

  task automatic test_banks();
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h2, 16'hFFFF);
    chk(cmdKind, ddr3r_pkg::DDR3R_CMD_ACT);
    chk(cmdAddr, 16'hFFFF);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h5, 16'h0000);
    chk(bankOpen, 16'h0024);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_PRE, 3'h2, 16'h0000);
    chk({cmdBank, bankOpen}, {3'h2, 16'h0020});
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_PRE, 3'h0, 16'h0400);
    chk(bankOpen, 16'h0000);
    chk(strobeCnt[0], 4);
    $display("bank test done");
  endtask

  task automatic test_mode();
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_MODE, 3'h3, 16'hA5C3);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_MODE, 3'h0, 16'h0001);
    // Bank select above three names no mode register
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_MODE, 3'h4, 16'hFFFF);
    chk(modeRegs, {64'h0, 64'hA5C3000000000001});
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h3, 16'h0000);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_READ, 3'h3, 16'h1155);
    chk({cmdBurstChop, cmdAutoPre, cmdCol, bankOpen}, {2'b00, 10'h155, 16'h0008});
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_WRITE, 3'h3, 16'h07AA);
    chk({cmdBurstChop, cmdAutoPre, cmdCol, bankOpen}, {2'b11, 10'h3AA, 16'h0000});
    // Fixed four-beat chop ignores bit twelve
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_MODE, 3'h0, 16'h0002);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h3, 16'h0000);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_READ, 3'h3, 16'h1400);
    chk({cmdBurstChop, cmdAutoPre, cmdCol, bankOpen}, {2'b11, 10'h000, 16'h0000});
    $display("mode test done");
  endtask

  task automatic test_ranks();
    m.issue(2'h3, ddr3r_pkg::DDR3R_CMD_ACT, 3'h1, 16'h0000);
    chk(bankOpen, 16'h0000);
    m.issue(2'h1, ddr3r_pkg::DDR3R_CMD_ACT, 3'h7, 16'h1234);
    chk(bankOpen, 16'h8000);
    chk(strobeCnt[1], 1);
    @(posedge ref_clk);
    m.resetPinN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    m.resetPinN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk({bankOpen, modeRegs[63:0]}, {16'h0000, 64'hA5C3000000000002});
    $display("rank test done");
  endtask

  task automatic test_power();
    set_cke(2'h2);
    m.issue(2'h3, ddr3r_pkg::DDR3R_CMD_NOP, 3'h0, 16'h0000);
    chk(pwrState, 4'h1);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h1, 16'h0000);
    chk(bankOpen, 16'h0000);
    set_cke(2'h3);
    m.issue(2'h3, ddr3r_pkg::DDR3R_CMD_NOP, 3'h0, 16'h0000);
    chk(pwrState, 4'h0);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h1, 16'h0000);
    set_cke(2'h2);
    m.issue(2'h3, ddr3r_pkg::DDR3R_CMD_NOP, 3'h0, 16'h0000);
    chk(pwrState, 4'h2);
    set_cke(2'h3);
    m.odtIn <= 2'h1;
    // The exit edge takes no command, so a spare frame first
    m.issue(2'h3, ddr3r_pkg::DDR3R_CMD_NOP, 3'h0, 16'h0000);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_PRE, 3'h0, 16'h0400);
    chk({pwrState, odtActive, bankOpen}, {4'h0, 2'h1, 16'h0000});
    set_cke(2'h2);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_REF, 3'h0, 16'h0000);
    chk({pwrState, odtActive}, {4'h3, 2'h0});
    chk(m.refCount[0], 1);
    m.issue(2'h2, ddr3r_pkg::DDR3R_CMD_ACT, 3'h6, 16'h0000);
    chk(bankOpen, 16'h0000);
    // Exit with the memory clock standing still
    set_cke(2'h3);
    repeat (5) @(posedge ref_clk);
    chk(pwrState, 4'h0);
    $display("power test done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_banks();
    test_mode();
    test_ranks();
    test_power();
    complete_run();
  end

  // About 24 frames of 8 cycles expected; generous margin on top
  initial begin
    #100000;
    badCount++;
    $display("Error at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule
